// ### buf_mgr_model.sv
/* Buffer manager model: grants pointer requests and takes buffer bytes.
   Assumes the block's byte handshake on the same clock. */
`timescale 1ns/100ps
`default_nettype none
module buf_mgr_model (
    // Clock, reset, pacing and block side
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic bufferRequest,
    input wire logic bufWrValid,
    input wire logic [7:0] bufWrData,
    // Answers
    output logic bufferReady,
    output logic bufWrReady
);
    logic [7:0] got [$];
    int grants = 0;
    int seed = 32'h3f0c6f9f;
    logic [31:0] r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bufferReady <= 1'b0;
            bufWrReady <= 1'b0;
        end else begin
            r = $random(seed);
            // Grant is one pulse, late at random when slow, so the wait path is hit
            bufferReady <= bufferRequest && !bufferReady && (r[1] || !slow);
            bufWrReady <= r[0] || !slow;
            if (bufferRequest && bufferReady) grants++;
            if (bufWrValid && bufWrReady) got.push_back(bufWrData);
        end
    end
endmodule
`default_nettype wire

// ### ecc_corr_pkg.sv
/*
 * Shared constants for the correction and parameter block: register
 * indices, field positions, reset values, command codes and shift limits.
 * Assumes a byte-wide register model placed on a 32-bit APB, one word each.
 */
`default_nettype none
package ecc_corr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_ERROR = 8'h21;
    localparam logic [7:0] IDX_GAPFILL = 8'h22;
    localparam logic [7:0] IDX_PADFILL = 8'h23;
    localparam logic [7:0] IDX_CYLLO = 8'h24;
    localparam logic [7:0] IDX_CYLHI = 8'h25;
    localparam logic [7:0] IDX_DRVHEAD = 8'h26;
    localparam logic [7:0] IDX_STATUS = 8'h27;
    localparam logic [7:0] IDX_SYNCLEN = 8'h30;
    localparam logic [7:0] IDX_PTRLO = 8'h34;
    localparam logic [7:0] IDX_PTRHI = 8'h35;
    localparam logic [7:0] IDX_BUFCTL = 8'h37;
    localparam logic [7:0] IDX_IFSTAT = 8'h38;
    localparam logic [7:0] IDX_DRVCTL = 8'h3B;
    localparam logic [7:0] IDX_ALTSEC = 8'h3C;
    localparam logic [7:0] IDX_DRQWR = 8'h3F;
    // Field positions
    localparam int BIT_PTRLOAD = 0;
    localparam int BIT_BUFWRDIR = 2;
    localparam int BIT_REQSEEN = 1;
    localparam int BIT_DONE = 3;
    localparam int BIT_ACCESS = 3;
    localparam int BIT_REQDIS = 6;
    localparam int BIT_ECCMODE = 7;
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_WFAULT = 5;
    localparam int ST_ERROR = 0;
    localparam int ER_ECC = 6;
    localparam int ER_ABORT = 2;
    localparam int ER_NOTREADY = 1;
    localparam int ER_WFAULT = 0;
    // Command byte: opcode in [7:5], options below
    localparam logic [2:0] OP_CORRECT = 3'b100;
    localparam logic [2:0] OP_SETPARAM = 3'b101;
    localparam logic [2:0] OP_LOADPARAM = 3'b110;
    localparam int OPT_P = 0;
    localparam int OPT_E = 4;
    localparam int OPT_H = 3;
    localparam int OPT_S = 2;
    localparam int OPT_Z = 1;
    localparam int OPT_R = 0;
    localparam int OPT_D = 2;
    localparam int OPT_K = 1;
    localparam int OPT_U = 0;
    // Values
    localparam logic [7:0] ALT_SECTOR_FILL = 8'hFF;
    localparam logic [55:0] ECC_POLY = 56'h80_0000_0000_0B01;
    localparam logic [10:0] BASE_SECTOR = 11'h080;
    localparam logic [4:0] SPAN_5 = 5'h05;
    localparam logic [4:0] SPAN_11 = 5'h0B;
    localparam logic [4:0] SPAN_22 = 5'h16;
    typedef enum logic [1:0] {CODE_RLL, CODE_MFM, CODE_NRZ} coding_t;
endpackage
`default_nettype wire

// ### ecc_corr_properties.sv
/* Port checker for the correction and parameter block.
   Assumes one clock domain; bound to every instance of the block. */
`timescale 1ns/100ps
`default_nettype none
module ecc_corr_properties
    import ecc_corr_pkg::*;
(
    // Clock, reset and APB
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Buffer and micro side
    input wire logic bufferRequest,
    input wire logic bufferReady,
    input wire logic bufWrValid,
    input wire logic [7:0] bufWrData,
    input wire logic bufWrReady,
    input wire logic microDataRequest,
    input wire logic microInterrupt,
    // Parameters
    input wire coding_t codingMode,
    input wire logic eccSevenByte,
    input wire logic [4:0] correctionSpan
);
    logic [3:0] age_ff;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence apbSetup;
        psel && !penable;
    endsequence
    // Cycles since the last APB transfer; parameters may move only shortly after one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) age_ff <= 4'hF;
        else age_ff <= (psel && penable && pready) ? 4'h0 : age_ff + {3'b000, age_ff != 4'hF};
    end
    apb_answer_a: assert property (apbSetup |=> pready)
        else $error("setup cycle not answered in the next cycle");
    req_pair_a: assert property ($rose(bufferRequest) |-> microDataRequest)
        else $error("buffer request raised without micro request");
    req_drop_a: assert property (bufferRequest && bufferReady |-> ##[1:2] !bufferRequest)
        else $error("buffer request held after ready");
    wait_ready_a: assert property (bufferRequest |-> !bufWrValid)
        else $error("buffer byte offered before ready");
    byte_hold_a: assert property (bufWrValid && !bufWrReady |=> bufWrValid && $stable(bufWrData))
        else $error("buffer byte changed before taken");
    irq_idle_a: assert property (microInterrupt |-> !bufWrValid && !bufferRequest)
        else $error("interrupt while transfer still running");
    span_pair_a: assert property (eccSevenByte ? correctionSpan != SPAN_5 : correctionSpan != SPAN_22)
        else $error("span does not suit ecc length");
    param_hold_a: assert property (!$stable({codingMode, eccSevenByte, correctionSpan}) |-> age_ff < 4'h8)
        else $error("parameter changed without a command");
endmodule
bind ecc_correction_and_param_setup ecc_corr_properties chk_u (.clk, .rst, .psel, .penable,
    .pready, .bufferRequest, .bufferReady, .bufWrValid, .bufWrData, .bufWrReady,
    .microDataRequest, .microInterrupt, .codingMode, .eccSevenByte, .correctionSpan);
`default_nettype wire

// ### ecc_correction_and_param_setup.sv
/*
 * Correction computation and drive parameter latch of the disk controller,
 * with its byte-register model on an APB slave.
 * Assumes the ECC checker presents the syndrome on syndromeIn and the
 * buffer manager takes one byte per cycle with bufWrValid and bufWrReady.
 */
`timescale 1ns/100ps
`default_nettype none
module ecc_correction_and_param_setup
    import ecc_corr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive and ECC checker
    input wire logic driveReady,
    input wire logic writeFaultInput,
    input wire logic indexPulse,
    input wire logic [55:0] syndromeIn,
    // Buffer manager
    output logic bufferRequest,
    input wire logic bufferReady,
    output logic bufWrValid,
    output logic [7:0] bufWrData,
    input wire logic bufWrReady,
    // Microcontroller signals
    output logic microDataRequest,
    output logic microInterrupt,
    // Parameters to the formatter
    output coding_t codingMode,
    output logic eccSevenByte,
    output logic headFourBits,
    output logic [4:0] correctionSpan,
    output logic relocationEnable,
    output logic hardSector,
    output logic [10:0] sectorSize,
    output logic [7:0] gateDelay,
    output logic [7:0] gapData,
    output logic [7:0] padData
);
    typedef enum logic [2:0] {
        S_IDLE, S_ACCEPT, S_WAITBUF, S_WAITIDX, S_SYND, S_SHIFT, S_RESULT, S_DONE
    } state_t;

    typedef struct packed {
        state_t state;
        logic [7:0] cmd;
        logic [5:0][7:0] taskFile;
        logic [7:0] errFlags;
        logic statErr;
        logic [7:0] syncLen;
        logic [7:0] ptrLo;
        logic [7:0] ptrHi;
        logic [7:0] bufCtl;
        logic done;
        logic reqSeen;
        logic [7:0] drvCtl;
        logic [7:0] altSector;
        logic [7:0] drqWr;
        logic eccLen7;
        logic head4;
        logic spanWide;
        logic codeNrz;
        logic reloc;
        logic hardSec;
        logic ifMode;
        logic userSize;
        logic [7:0] gDelay;
        logic [7:0] gData;
        logic [7:0] pData;
        logic [10:0] userSect;
        logic [55:0] sr;
        logic [13:0] cnt;
        logic [3:0] idx;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic bufReq;
        logic mdrq;
        logic bufValid;
        logic [7:0] bufData;
        logic idxPrev;
    } st_t;

    st_t cur_ff;
    st_t nxt_st;

    // Register index of a byte address, or zero when unaligned or out of range
    function automatic logic [7:0] regIndex(input logic [11:0] a);
        regIndex = (a[1:0] == 2'b00 && a[11:10] == 2'b00) ? a[9:2] : 8'h00;
    endfunction

    function automatic logic [4:0] spanOf(input logic e7, input logic wide);
        if (e7) begin
            spanOf = wide ? SPAN_22 : SPAN_11;
        end else begin
            spanOf = wide ? SPAN_11 : SPAN_5;
        end
    endfunction

    function automatic logic [10:0] sizeOf(input st_t s);
        if (s.userSize) begin
            sizeOf = s.userSect;
        end else begin
            sizeOf = 11'(BASE_SECTOR << s.taskFile[5][6:5]);
        end
    endfunction

    logic [7:0] rdIdx;
    logic [7:0] rdVal;
    logic mapped;
    logic [3:0] nSyn;
    logic [3:0] nPat;
    logic [55:0] widthMask;
    logic [55:0] spanMask;
    logic [55:0] shifted;
    logic [31:0] pattern;
    logic [15:0] offset;
    logic [13:0] limit;
    logic idxEdge;
    logic reqEnabled;

    always_comb begin
        rdIdx = regIndex(paddr);
        mapped = 1'b1;
        case (rdIdx)
            IDX_ERROR: rdVal = cur_ff.errFlags;
            IDX_GAPFILL: rdVal = cur_ff.taskFile[1];
            IDX_PADFILL: rdVal = cur_ff.taskFile[2];
            IDX_CYLLO: rdVal = cur_ff.taskFile[3];
            IDX_CYLHI: rdVal = cur_ff.taskFile[4];
            IDX_DRVHEAD: rdVal = cur_ff.taskFile[5];
            IDX_STATUS: rdVal = {cur_ff.state != S_IDLE, driveReady, writeFaultInput,
                                 4'h0, cur_ff.statErr};
            IDX_SYNCLEN: rdVal = cur_ff.syncLen;
            IDX_PTRLO: rdVal = cur_ff.ptrLo;
            IDX_PTRHI: rdVal = cur_ff.ptrHi;
            IDX_BUFCTL: rdVal = cur_ff.bufCtl;
            IDX_IFSTAT: rdVal = {4'h0, cur_ff.done, 1'b0, cur_ff.reqSeen, 1'b0};
            IDX_DRVCTL: rdVal = cur_ff.drvCtl;
            IDX_ALTSEC: rdVal = cur_ff.altSector;
            IDX_DRQWR: rdVal = 8'h00;
            default: begin
                rdVal = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        nSyn = cur_ff.eccLen7 ? 4'h7 : 4'h4;
        nPat = (cur_ff.spanWide || cur_ff.eccLen7) ? 4'h4 : 4'h3;
        widthMask = cur_ff.eccLen7 ? {56{1'b1}} : {24'h000000, 32'hFFFF_FFFF};
        spanMask = widthMask & ~({56{1'b1}} << spanOf(cur_ff.eccLen7, cur_ff.spanWide));
        shifted = ((cur_ff.sr >> 1) ^ (cur_ff.sr[0] ? ECC_POLY : 56'h0)) & widthMask;
        pattern = 32'(cur_ff.sr[31:0] << (5'd8 - 5'(cur_ff.cnt[2:0])));
        offset = {5'h00, cur_ff.cnt[13:3]};
        limit = {sizeOf(cur_ff), 3'b000};
        idxEdge = indexPulse && !cur_ff.idxPrev;
        reqEnabled = !cur_ff.drqWr[BIT_REQDIS];
    end

    always_comb begin
        nxt_st = cur_ff;
        nxt_st.idxPrev = indexPulse;
        // No wait state: data is prepared in setup, handed over in the first access cycle
        if (psel && !penable && !cur_ff.pready) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = !mapped;
            nxt_st.prdata = pwrite ? 32'h0 : {24'h0, rdVal};
        end else begin
            nxt_st.pready = 1'b0;
            nxt_st.pslverr = 1'b0;
        end
        if (psel && penable && cur_ff.pready && pwrite && mapped) begin
            case (rdIdx)
                IDX_ERROR: nxt_st.taskFile[0] = pwdata[7:0];
                IDX_GAPFILL: nxt_st.taskFile[1] = pwdata[7:0];
                IDX_PADFILL: nxt_st.taskFile[2] = pwdata[7:0];
                IDX_CYLLO: nxt_st.taskFile[3] = pwdata[7:0];
                IDX_CYLHI: nxt_st.taskFile[4] = pwdata[7:0];
                IDX_DRVHEAD: nxt_st.taskFile[5] = pwdata[7:0];
                IDX_STATUS: begin
                    // Commands while busy are dropped rather than queued
                    if (cur_ff.state == S_IDLE) begin
                        nxt_st.cmd = pwdata[7:0];
                        nxt_st.state = S_ACCEPT;
                    end
                end
                IDX_SYNCLEN: nxt_st.syncLen = pwdata[7:0];
                IDX_PTRLO: nxt_st.ptrLo = pwdata[7:0];
                IDX_PTRHI: nxt_st.ptrHi = pwdata[7:0];
                IDX_BUFCTL: nxt_st.bufCtl = pwdata[7:0];
                IDX_IFSTAT: begin
                    if (pwdata[BIT_DONE]) begin
                        nxt_st.done = 1'b0;
                    end
                    if (pwdata[BIT_REQSEEN]) begin
                        nxt_st.reqSeen = 1'b1;
                        nxt_st.mdrq = 1'b0;
                    end
                end
                IDX_DRVCTL: nxt_st.drvCtl = pwdata[7:0];
                IDX_ALTSEC: nxt_st.altSector = pwdata[7:0];
                IDX_DRQWR: nxt_st.drqWr = pwdata[7:0];
                default: nxt_st.drqWr = cur_ff.drqWr;
            endcase
        end

        case (cur_ff.state)
            S_IDLE: nxt_st.bufValid = 1'b0;
            S_ACCEPT: begin
                nxt_st.altSector = ALT_SECTOR_FILL;
                nxt_st.errFlags = 8'h00;
                nxt_st.statErr = 1'b0;
                nxt_st.reqSeen = 1'b0;
                if (!driveReady || writeFaultInput) begin
                    nxt_st.errFlags[ER_ABORT] = 1'b1;
                    nxt_st.errFlags[ER_NOTREADY] = !driveReady;
                    nxt_st.errFlags[ER_WFAULT] = writeFaultInput;
                    nxt_st.statErr = 1'b1;
                    nxt_st.state = S_DONE;
                end else if (cur_ff.cmd[7:5] == OP_SETPARAM) begin
                    nxt_st.eccLen7 = cur_ff.cmd[OPT_E];
                    nxt_st.head4 = cur_ff.cmd[OPT_H];
                    nxt_st.spanWide = cur_ff.cmd[OPT_S];
                    nxt_st.codeNrz = cur_ff.cmd[OPT_Z];
                    nxt_st.reloc = cur_ff.cmd[OPT_R];
                    nxt_st.state = S_DONE;
                end else if (cur_ff.cmd[7:5] == OP_LOADPARAM) begin
                    nxt_st.hardSec = cur_ff.cmd[OPT_D];
                    nxt_st.ifMode = cur_ff.cmd[OPT_K];
                    nxt_st.userSize = cur_ff.cmd[OPT_U];
                    nxt_st.gDelay = cur_ff.cmd[OPT_D] ? cur_ff.syncLen : cur_ff.taskFile[0];
                    nxt_st.gData = cur_ff.taskFile[1];
                    nxt_st.pData = cur_ff.taskFile[2];
                    nxt_st.userSect = {cur_ff.taskFile[4][2:0], cur_ff.taskFile[3]};
                    nxt_st.state = S_DONE;
                end else if (cur_ff.cmd[7:5] == OP_CORRECT) begin
                    nxt_st.sr = syndromeIn & widthMask;
                    nxt_st.cnt = 14'h0;
                    nxt_st.idx = 4'h0;
                    if (reqEnabled) begin
                        nxt_st.bufReq = 1'b1;
                        nxt_st.mdrq = 1'b1;
                        nxt_st.state = S_WAITBUF;
                    end else begin
                        nxt_st.state = S_SYND;
                    end
                end else begin
                    // Codes outside this block complete at once; only errFlags, statErr, reqSeen, altSector and done change
                    nxt_st.state = S_DONE;
                end
            end
            S_WAITBUF: begin
                if (bufferReady) begin
                    nxt_st.bufReq = 1'b0;
                    nxt_st.state = S_WAITIDX;
                end
            end
            S_WAITIDX: begin
                if (idxEdge) begin
                    nxt_st.state = S_SYND;
                end
            end
            S_SYND: begin
                if (!cur_ff.bufValid || bufWrReady) begin
                    if (cur_ff.idx == nSyn) begin
                        nxt_st.bufValid = 1'b0;
                        nxt_st.idx = 4'h0;
                        nxt_st.state = cur_ff.cmd[OPT_P] ? S_DONE : S_SHIFT;
                    end else begin
                        nxt_st.bufValid = 1'b1;
                        nxt_st.bufData = 8'(cur_ff.sr >> {nSyn - cur_ff.idx - 4'h1, 3'b000});
                        nxt_st.idx = cur_ff.idx + 4'h1;
                    end
                end
            end
            S_SHIFT: begin
                if (cur_ff.sr != 56'h0 && (cur_ff.sr & ~spanMask) == 56'h0) begin
                    nxt_st.state = S_RESULT;
                end else if (cur_ff.cnt > limit) begin
                    nxt_st.errFlags[ER_ECC] = 1'b1;
                    nxt_st.statErr = 1'b1;
                    nxt_st.state = S_RESULT;
                end else begin
                    nxt_st.sr = shifted;
                    nxt_st.cnt = cur_ff.cnt + 14'h1;
                end
            end
            S_RESULT: begin
                if (!cur_ff.bufValid || bufWrReady) begin
                    if (cur_ff.idx == nPat + 4'h2) begin
                        nxt_st.bufValid = 1'b0;
                        nxt_st.state = S_DONE;
                    end else begin
                        nxt_st.bufValid = 1'b1;
                        case (cur_ff.idx)
                            4'h0: nxt_st.bufData = offset[15:8];
                            4'h1: nxt_st.bufData = offset[7:0];
                            default: nxt_st.bufData =
                                8'(pattern >> {4'h5 - cur_ff.idx, 3'b000});
                        endcase
                        nxt_st.idx = cur_ff.idx + 4'h1;
                    end
                end
            end
            S_DONE: begin
                nxt_st.done = 1'b1;
                nxt_st.mdrq = 1'b0;
                nxt_st.bufReq = 1'b0;
                nxt_st.state = S_IDLE;
            end
            default: nxt_st.state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.state <= S_IDLE;
            cur_ff.eccLen7 <= 1'b1;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // Output flops
    logic microInterrupt_ff;
    logic [10:0] sectorSize_ff;
    coding_t codingMode_ff;
    logic [4:0] span_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            microInterrupt_ff <= 1'b0;
            sectorSize_ff <= 11'h0;
            codingMode_ff <= CODE_RLL;
            span_ff <= SPAN_11;
        end else begin
            microInterrupt_ff <= nxt_st.done;
            sectorSize_ff <= sizeOf(cur_ff);
            codingMode_ff <= !cur_ff.ifMode ? CODE_RLL
                           : (cur_ff.codeNrz ? CODE_NRZ : CODE_MFM);
            span_ff <= spanOf(nxt_st.eccLen7, nxt_st.spanWide);
        end
    end

    assign prdata = cur_ff.prdata;
    assign pready = cur_ff.pready;
    assign pslverr = cur_ff.pslverr;
    assign bufferRequest = cur_ff.bufReq;
    assign bufWrValid = cur_ff.bufValid;
    assign bufWrData = cur_ff.bufData;
    assign microDataRequest = cur_ff.mdrq;
    assign microInterrupt = microInterrupt_ff;
    assign codingMode = codingMode_ff;
    assign eccSevenByte = cur_ff.eccLen7;
    assign headFourBits = cur_ff.head4;
    assign correctionSpan = span_ff;
    assign relocationEnable = cur_ff.reloc && cur_ff.userSize;
    assign hardSector = cur_ff.hardSec;
    assign sectorSize = sectorSize_ff;
    assign gateDelay = cur_ff.gDelay;
    assign gapData = cur_ff.gData;
    assign padData = cur_ff.pData;
endmodule
`default_nettype wire

// ### ecc_correction_and_param_setup_tb.sv
/* Self-checking bench for the correction and parameter block.
   Assumes the buffer manager model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module ecc_correction_and_param_setup_tb
    import ecc_corr_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, driveReady, writeFaultInput;
    logic indexPulse, slow, bufferRequest, bufferReady, bufWrValid, bufWrReady, err;
    logic microDataRequest, microInterrupt, eccSevenByte, headFourBits, relocationEnable, hardSector;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [55:0] syndromeIn;
    logic [7:0] bufWrData, gateDelay, gapData, padData, rd;
    coding_t codingMode;
    logic [4:0] correctionSpan;
    logic [10:0] sectorSize;
    logic [7:0] tf [7];
    logic [7:0] ti [7] = '{IDX_ERROR, IDX_GAPFILL, IDX_PADFILL, IDX_CYLLO, IDX_CYLHI, IDX_DRVHEAD,
        IDX_SYNCLEN};
    logic [7:0] sp [3] = '{8'hA0, 8'hA4, 8'hB0};
    int fails, tests_run, seed, n, np, g;
    ecc_correction_and_param_setup dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .driveReady, .writeFaultInput, .indexPulse, .syndromeIn,
        .bufferRequest, .bufferReady, .bufWrValid, .bufWrData, .bufWrReady, .microDataRequest,
        .microInterrupt, .codingMode, .eccSevenByte, .headFourBits, .correctionSpan,
        .relocationEnable, .hardSector, .sectorSize, .gateDelay, .gapData, .padData);
    buf_mgr_model bm_u (.clk, .rst, .slow, .bufferRequest, .bufWrValid, .bufWrData, .bufferReady,
        .bufWrReady);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        indexPulse = 1'b0;
        forever begin
            repeat (62) @(posedge clk);
            indexPulse <= 1'b1;
            repeat (2) @(posedge clk);
            indexPulse <= 1'b0;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        tests_run++;
        if (v !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) chk("pready", 1, pready);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(nm, e, rd);
    endtask
    task automatic cmd(input logic [7:0] c);
        int k;
        k = 0;
        apb(1'b1, IDX_STATUS, c);
        do begin
            apb(1'b0, IDX_IFSTAT, 8'h00);
            k++;
            if (microDataRequest === 1'b1) begin
                apb(1'b1, IDX_IFSTAT, 8'h02);
                chk("mdrq", 0, microDataRequest);
            end
        end while (rd[BIT_DONE] !== 1'b1 && k < 5000);
        chk("interrupt", 1, microInterrupt);
        apb(1'b1, IDX_IFSTAT, 8'h08);
    endtask
    task automatic prep(input logic dis);
        apb(1'b1, IDX_BUFCTL, 8'h00);
        apb(1'b1, IDX_PTRLO, 8'h10);
        apb(1'b1, IDX_PTRHI, 8'h00);
        apb(1'b1, IDX_DRQWR, {1'b0, dis, 6'h00});
        apb(1'b1, IDX_DRVCTL, 8'h08);
        apb(1'b1, IDX_BUFCTL, 8'h01);
        apb(1'b1, IDX_DRVCTL, 8'h00);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #380000;
        fails++;
        stop_test();
    end
    initial begin
        {psel, penable, pwrite, writeFaultInput, slow, rst, driveReady} = 7'h03;
        paddr = 12'h000;
        pwdata = 32'h0;
        syndromeIn = 56'h0;
        fails = 0;
        tests_run = 0;
        seed = 32'h3f0c6f9f;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("ecc7", 1, eccSevenByte);
        chk("head4", 0, headFourBits);
        chk("span", SPAN_11, correctionSpan);
        chk("hard", 0, hardSector);
        chk("size", 128, sectorSize);
        apb(1'b1, IDX_ALTSEC, 8'h00);
        cmd(8'hA2);
        chk("coding", CODE_RLL, codingMode);
        rchk("altsec", IDX_ALTSEC, ALT_SECTOR_FILL);
        $display("test defaults done");
        for (int i = 0; i < 7; i++) begin
            tf[i] = 8'($random(seed));
            apb(1'b1, ti[i], tf[i]);
        end
        cmd(8'hC7);
        chk("delay", tf[6], gateDelay);
        chk("gap", tf[1], gapData);
        chk("pad", tf[2], padData);
        chk("size", {tf[4][2:0], tf[3]}, sectorSize);
        chk("hard", 1, hardSector);
        cmd(8'hC2);
        chk("delay", tf[0], gateDelay);
        chk("size", 11'h080 << tf[5][6:5], sectorSize);
        chk("hard", 0, hardSector);
        $display("test load done");
        cmd(8'hC3);
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, IDX_ALTSEC, 8'h00);
            cmd({3'b101, i[4:0]});
            chk("ecc7", i[4], eccSevenByte);
            chk("head4", i[3], headFourBits);
            chk("span", i[4] ? (i[2] ? 22 : 11) : (i[2] ? 11 : 5), correctionSpan);
            chk("coding", i[1] ? CODE_NRZ : CODE_MFM, codingMode);
            chk("reloc", i[0], relocationEnable);
            rchk("altsec", IDX_ALTSEC, ALT_SECTOR_FILL);
            rchk("errflags", IDX_ERROR, 8'h00);
        end
        $display("test set done");
        apb(1'b1, IDX_DRVHEAD, 8'h00);
        cmd(8'hC2);
        for (int i = 0; i < 6; i++) begin
            cmd(sp[i % 3]);
            prep(1'b0);
            slow <= i[0];
            syndromeIn <= 56'({$random(seed), $random(seed)});
            bm_u.got.delete();
            cmd({7'b1000000, i >= 3});
            n = sp[i % 3][4] ? 7 : 4;
            np = (sp[i % 3][4] || sp[i % 3][2]) ? 4 : 3;
            chk("count", (i >= 3) ? n : n + 2 + np, bm_u.got.size());
            for (int k = 0; k < n; k++) chk("syndrome", syndromeIn[8 * (n - 1 - k) +: 8], bm_u.got[k]);
        end
        g = bm_u.grants;
        prep(1'b1);
        cmd(8'h81);
        chk("grants", g, bm_u.grants);
        // Error inside the span at the first check: offset zero, no error flags
        syndromeIn <= 56'h1;
        bm_u.got.delete();
        cmd(8'h80);
        chk("count", n + 2 + np, bm_u.got.size());
        chk("offset", 0, {bm_u.got[n], bm_u.got[n + 1]});
        rchk("errflags", IDX_ERROR, 8'h00);
        rchk("status", IDX_STATUS, 8'h40);
        $display("test correct done");
        driveReady <= 1'b0;
        cmd(8'hA0);
        rchk("errflags", IDX_ERROR, 8'h06);
        driveReady <= 1'b1;
        writeFaultInput <= 1'b1;
        cmd(8'hA0);
        rchk("errflags", IDX_ERROR, 8'h05);
        writeFaultInput <= 1'b0;
        apb(1'b1, 8'h00, 8'h5A);
        chk("slverr", 1, err);
        $display("test abort done");
        cmd(8'hA8);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("head4", 0, headFourBits);
        chk("ecc7", 1, eccSevenByte);
        $display("test rereset done");
        stop_test();
    end
endmodule
`default_nettype wire
